//--- rtl/pdt_pkg.sv
// package: register map, field layout and timing constants of the down timer
package pdt_pkg;

    localparam int          PDT_ADR_W        = 8;
    localparam int          PDT_IDX_W        = PDT_ADR_W - 2;

    // register indices, byte address is four times the index
    localparam logic [PDT_IDX_W-1:0] PDT_IDX_COUNTER = 6'h08;
    localparam logic [PDT_IDX_W-1:0] PDT_IDX_CONTROL = 6'h09;
    localparam logic [PDT_IDX_W-1:0] PDT_IDX_OPTION  = 6'h0A;

    // control register fields
    localparam int          PDT_CTL_FLAG     = 7;
    localparam int          PDT_CTL_INHIBIT  = 6;
    localparam int          PDT_CTL_SRC      = 5;
    localparam int          PDT_CTL_PIN      = 4;
    localparam int          PDT_CTL_CLEAR    = 3;
    localparam int          PDT_CTL_SEL_HI   = 2;
    localparam int          PDT_CTL_SEL_LO   = 0;

    // option byte fields
    localparam int          PDT_OPT_FIXED    = 6;
    localparam int          PDT_OPT_SRC      = 5;
    localparam int          PDT_OPT_PIN      = 4;
    localparam int          PDT_OPT_SEL_HI   = 2;
    localparam int          PDT_OPT_SEL_LO   = 0;

    // reset and fixed values
    localparam logic [7:0]  PDT_OPT_ERASED   = 8'h00;
    localparam logic        PDT_INHIBIT_RST  = 1'b1;
    localparam logic [5:0]  PDT_FIXED_LOW    = 6'h3F;
    localparam logic [7:0]  PDT_COUNT_WRAP   = 8'hFF;
    localparam logic [7:0]  PDT_COUNT_INIT   = 8'h00;
    localparam logic [7:0]  PDT_COUNT_ONE    = 8'h01;

    // internal count clock is the system clock divided by four
    localparam int          PDT_INT_DIV      = 4;
    localparam int          PDT_INT_DIV_W    = $clog2(PDT_INT_DIV);
    localparam logic [PDT_INT_DIV_W-1:0] PDT_INT_LAST = PDT_INT_DIV_W'(PDT_INT_DIV - 1);

    localparam int          PDT_PRESC_W      = 7;

    typedef struct packed {
        logic       flag;
        logic       inhibit;
        logic       source_select;
        logic       pin_enable;
        logic [2:0] divider_sel;
    } pdt_ctrl_t;

endpackage : pdt_pkg

//--- rtl/pdt_timer.sv
// prescaled 8-bit down timer with option byte and classic wishbone slave
//
// Overview of operation
// - both select bits zero: internal clock, pin ignored
// - pin enable only: internal clock ANDed with pin
// - source select only: no prescaler input, stopped
// - both bits one: pin alone clocks prescaler
// - counter decrements, wraps 00 to FF, does not stop at zero
// - flag set at zero, cleared by reset/write
// - inhibit bit one suppresses the timer interrupt
// - interrupt only while flag set, inhibit clear
// - source select one external, zero oscillator/4
// - pin enable connects or disconnects the pin
// - in software mode writing divider clear zeroes prescaler, reads zero
// - select bits divide by two to their power
// - in software mode control bits read/write except bit three
// - option bit six selects fixed configuration mode
// - fixed mode loads bits 5,2,1,0 at reset
// - fixed mode forces pin enable, clear bits one
// - fixed mode shows bits 7,6; low six ones
// - software mode resets bits 5,4,2,1,0 from option
// - option source bit one pin, zero internal
// - option pin bit only seeds software mode
// - option divider bits share the same encoding
// - option byte erased zero, survives any reset
`timescale 1ns/1ns
module pdt_timer
    import pdt_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [PDT_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 timer_pin_i,
    input  wire logic                 opt_prog_i,
    input  wire logic [7:0]           opt_data_i,
    output logic                      timer_irq_o
);

    function automatic logic presc_hit(input logic [PDT_PRESC_W-1:0] p,
                                       input logic [2:0]             s);
        logic [PDT_PRESC_W-1:0] mask;
        mask = PDT_PRESC_W'((8'h01 << s) - 8'h01);
        return (p & mask) == mask;
    endfunction : presc_hit

    // ---------------- option byte, untouched by reset
    logic [7:0] option_byte = PDT_OPT_ERASED;

    always_ff @(posedge clk_i) begin
        if (opt_prog_i) begin
            option_byte <= opt_data_i;
        end
    end

    // ---------------- bus decode
    logic                 bus_req;
    logic [PDT_IDX_W-1:0] bus_idx;
    logic                 wr_fire;
    logic                 wr_ctrl;
    logic                 wr_count;
    logic                 fixed_mode;
    pdt_ctrl_t            ctrl;
    logic [7:0]           counter_value = PDT_COUNT_INIT;

    assign bus_req  = wb_cyc_i && wb_stb_i;
    assign bus_idx  = wb_adr_i[PDT_ADR_W-1:2];
    assign wr_fire  = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign wr_ctrl  = wr_fire && (bus_idx == PDT_IDX_CONTROL);
    assign wr_count = wr_fire && (bus_idx == PDT_IDX_COUNTER);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    logic [7:0] ctrl_read;

    always_comb begin
        if (fixed_mode) begin
            ctrl_read = {ctrl.flag, ctrl.inhibit, PDT_FIXED_LOW};
        end else begin
            ctrl_read = {ctrl.flag, ctrl.inhibit, ctrl.source_select,
                         ctrl.pin_enable, 1'b0, ctrl.divider_sel};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_ack_o) begin
            unique case (bus_idx)
                PDT_IDX_COUNTER: wb_dat_o <= {24'h00_0000, counter_value};
                PDT_IDX_CONTROL: wb_dat_o <= {24'h00_0000, ctrl_read};
                PDT_IDX_OPTION:  wb_dat_o <= {24'h00_0000, option_byte};
                default:         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------- control register and mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fixed_mode <= option_byte[PDT_OPT_FIXED];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl.inhibit       <= PDT_INHIBIT_RST;
            ctrl.source_select <= option_byte[PDT_OPT_SRC];
            ctrl.divider_sel   <= option_byte[PDT_OPT_SEL_HI:PDT_OPT_SEL_LO];
            if (option_byte[PDT_OPT_FIXED]) begin
                ctrl.pin_enable <= 1'b1;
            end else begin
                ctrl.pin_enable <= option_byte[PDT_OPT_PIN];
            end
        end else if (wr_ctrl) begin
            ctrl.inhibit <= wb_dat_i[PDT_CTL_INHIBIT];
            if (!fixed_mode) begin
                ctrl.source_select <= wb_dat_i[PDT_CTL_SRC];
                ctrl.pin_enable    <= wb_dat_i[PDT_CTL_PIN];
                ctrl.divider_sel   <= wb_dat_i[PDT_CTL_SEL_HI:PDT_CTL_SEL_LO];
            end
        end
    end

    // ---------------- pin synchroniser and edge
    logic pin_meta;
    logic pin_sync;
    logic pin_last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            pin_meta <= timer_pin_i;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    // ---------------- internal clock divide by four
    logic [PDT_INT_DIV_W-1:0] int_div;
    logic                     int_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_div <= '0;
        end else begin
            int_div <= int_div + PDT_INT_DIV_W'(1);
        end
    end

    assign int_tick = (int_div == PDT_INT_LAST);

    // ---------------- source select
    logic pin_en_eff;
    logic presc_in;

    assign pin_en_eff = fixed_mode || ctrl.pin_enable;

    always_comb begin
        unique case ({pin_en_eff, ctrl.source_select})
            2'b00: presc_in = int_tick;
            2'b10: presc_in = int_tick && pin_sync;
            2'b01: presc_in = 1'b0;
            2'b11: presc_in = pin_sync && !pin_last;
        endcase
    end

    // ---------------- prescaler
    logic [PDT_PRESC_W-1:0] presc;
    logic                   presc_clr;
    logic                   dec;

    assign presc_clr = wr_ctrl && !fixed_mode && wb_dat_i[PDT_CTL_CLEAR];

    always_ff @(posedge clk_i) begin
        if (rst_i || presc_clr) begin
            presc <= '0;
        end else if (presc_in) begin
            presc <= presc + PDT_PRESC_W'(1);
        end
    end

    assign dec = presc_in && !presc_clr && presc_hit(presc, ctrl.divider_sel);

    // ---------------- counter, unaffected by reset
    logic count_zero;

    always_ff @(posedge clk_i) begin
        if (wr_count) begin
            counter_value <= wb_dat_i[7:0];
        end else if (dec) begin
            counter_value <= counter_value - PDT_COUNT_ONE;
        end
    end

    assign count_zero = dec && !wr_count && (counter_value == PDT_COUNT_ONE);

    // ---------------- flag and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl.flag <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl.flag <= count_zero || wb_dat_i[PDT_CTL_FLAG];
        end else if (count_zero) begin
            ctrl.flag <= 1'b1;
        end
    end

    assign timer_irq_o = ctrl.flag && !ctrl.inhibit;

    // ---------------- assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence ctrl_read_s;
        wb_ack_o && bus_req && !wb_we_i && (bus_idx == PDT_IDX_CONTROL);
    endsequence

    sequence count_write_s;
        wr_count;
    endsequence

    wrap_past_zero_a: assert property (dec && !wr_count && counter_value == 8'h00
        |=> counter_value == PDT_COUNT_WRAP) else $error("no wrap to FF");

    one_step_a: assert property (dec && !wr_count
        |=> counter_value == $past(counter_value) - 8'h01)
        else $error("counter did not step once");

    flag_at_zero_a: assert property (dec && !wr_count && counter_value == 8'h01
        |=> ctrl.flag && counter_value == 8'h00) else $error("flag not set at zero");

    irq_inhibit_a: assert property (ctrl.inhibit |-> !timer_irq_o)
        else $error("irq while inhibited");

    irq_rise_a: assert property ($rose(timer_irq_o) |-> ctrl.flag && !$past(timer_irq_o)
        && !ctrl.inhibit) else $error("irq without cause");

    stopped_mode_a: assert property ((!pin_en_eff && ctrl.source_select && !presc_clr) [*2]
        |-> $stable(presc) && $stable(counter_value) || $past(wr_count))
        else $error("counter moved when stopped");

    gate_pin_a: assert property (pin_en_eff && !ctrl.source_select && !pin_sync
        |-> !presc_in) else $error("gated input ran with pin low");

    internal_src_a: assert property (!pin_en_eff && !ctrl.source_select
        |-> presc_in == (int_div == 2'd3)) else $error("internal source wrong");

    ext_edge_a: assert property (pin_en_eff && ctrl.source_select && presc_in
        |-> pin_sync && !pin_last) else $error("external pulse without edge");

    presc_clear_a: assert property (presc_clr |=> presc == 7'h00)
        else $error("prescaler not cleared");

    bypass_div_a: assert property (ctrl.divider_sel == 3'd0 && presc_in && !presc_clr
        |-> dec) else $error("bypass missed a pulse");

    clear_reads_zero_a: assert property (ctrl_read_s and !fixed_mode |-> wb_dat_o[3] == 1'b0)
        else $error("clear bit read as one");

    fixed_low_ones_a: assert property (ctrl_read_s and fixed_mode |-> wb_dat_o[5:0] == 6'h3F)
        else $error("fixed mode low bits not ones");

    fixed_cfg_hold_a: assert property (fixed_mode && wr_ctrl
        |=> $stable(ctrl.divider_sel) && $stable(ctrl.source_select) && ctrl.pin_enable)
        else $error("fixed config changed by write");

    count_load_a: assert property (count_write_s |=> counter_value == $past(wb_dat_i[7:0]))
        else $error("counter load lost");

    reset_seed_a: assert property ($fell(rst_i) && !$past(opt_prog_i)
        |-> ctrl.divider_sel == option_byte[2:0] && ctrl.source_select == option_byte[5]
        && fixed_mode == option_byte[6]) else $error("reset seed wrong");

    option_keep_a: assert property (!opt_prog_i |=> $stable(option_byte))
        else $error("option byte changed");

    sequence int_gap_s;
        !int_tick [*3] ##1 int_tick;
    endsequence

    int_period_a: assert property (int_tick |=> int_gap_s)
        else $error("internal tick not every four clocks");

    pin_ignored_a: assert property (!pin_en_eff
        |-> presc_in == (int_tick && !ctrl.source_select))
        else $error("pin reached count logic while disconnected");

    gate_high_a: assert property (pin_en_eff && !ctrl.source_select && pin_sync
        |-> presc_in == int_tick) else $error("gated input lost a tick");

    presc_step_a: assert property (presc_in && !presc_clr
        |=> presc == $past(presc) + 7'h01) else $error("prescaler did not step");

    presc_hold_a: assert property (!presc_in && !presc_clr
        |=> $stable(presc)) else $error("prescaler moved without input");

    dec_needs_in_a: assert property (dec |-> presc_in)
        else $error("decrement without prescaler input");

    div_two_a: assert property (ctrl.divider_sel == 3'd1 && presc_in && !presc[0]
        |-> !dec) else $error("divide by two fired early");

    count_hold_a: assert property (!dec && !wr_count
        |=> $stable(counter_value)) else $error("counter moved without pulse");

    flag_hold_a: assert property (ctrl.flag && !wr_ctrl |=> ctrl.flag)
        else $error("flag lost without clear");

    flag_sw_clear_a: assert property (wr_ctrl && !wb_dat_i[PDT_CTL_FLAG] && !count_zero
        |=> !ctrl.flag) else $error("flag not cleared by write");

    set_wins_a: assert property (wr_ctrl && count_zero |=> ctrl.flag)
        else $error("clear beat flag set");

    irq_fall_a: assert property ($fell(timer_irq_o) |-> !ctrl.flag || ctrl.inhibit)
        else $error("irq dropped with cause present");

    inhibit_write_a: assert property (wr_ctrl
        |=> ctrl.inhibit == $past(wb_dat_i[PDT_CTL_INHIBIT]))
        else $error("inhibit write lost");

    soft_write_a: assert property (wr_ctrl && !fixed_mode
        |=> ctrl.source_select == $past(wb_dat_i[PDT_CTL_SRC])
        && ctrl.pin_enable == $past(wb_dat_i[PDT_CTL_PIN])
        && ctrl.divider_sel == $past(wb_dat_i[PDT_CTL_SEL_HI:PDT_CTL_SEL_LO]))
        else $error("software control write lost");

    mode_hold_a: assert property (!$past(rst_i) |-> $stable(fixed_mode))
        else $error("mode changed outside reset");

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ack_answer_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");

    count_read_a: assert property (wb_ack_o && bus_req && !wb_we_i
        && bus_idx == PDT_IDX_COUNTER |-> wb_dat_o == {24'h00_0000, $past(counter_value)})
        else $error("counter read wrong");

    opt_read_a: assert property (wb_ack_o && bus_req && !wb_we_i
        && bus_idx == PDT_IDX_OPTION && !$past(opt_prog_i)
        |-> wb_dat_o == {24'h00_0000, option_byte}) else $error("option read wrong");

endmodule : pdt_timer

//--- bench/pdt_pin_src.sv
// partner model: external event source on the timer pin
`timescale 1ns/1ns
module pdt_pin_src (
    input  wire logic clk_i,
    output logic      pin_o
);
    initial pin_o = 1'b0;

    // one event: high three cycles, low three cycles
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : pulse

    // static level for gating
    task automatic hold(input logic v);
        @(posedge clk_i);
        pin_o <= v;
    endtask : hold
endmodule : pdt_pin_src

//--- bench/testbench.sv
// testbench: directed scenarios for the prescaled down timer
`timescale 1ns/1ns
module testbench;
    import pdt_pkg::*;
    localparam logic [7:0] A_CNT = {PDT_IDX_COUNTER, 2'b00};
    localparam logic [7:0] A_CTL = {PDT_IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_OPT = {PDT_IDX_OPTION, 2'b00};
    localparam logic [7:0] A_BAD = 8'h3C;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq, opt_prog, tpin;
    logic [7:0]  adr, opt_data;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o, q, r;
    int          n_fail, cmp_count;

    pdt_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .timer_pin_i(tpin), .opt_prog_i(opt_prog),
        .opt_data_i(opt_data), .timer_irq_o(irq));
    pdt_pin_src src (.clk_i(clk_i), .pin_o(tpin));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] o);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        o = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) n_fail++;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hF, r);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset

    task automatic prog(input logic [7:0] v);
        @(posedge clk_i);
        opt_prog <= 1'b1;
        opt_data <= v;
        @(posedge clk_i);
        opt_prog <= 1'b0;
    endtask : prog

    task automatic t_reset();
        rd(A_CTL); check("ctl rst", q, 32'h40);
        rd(A_OPT); check("opt rst", q, 32'h00);
        wr(A_OPT, 8'h5A); rd(A_OPT); check("opt ro", q, 32'h00);
        wr(A_BAD, 8'h12);
        rd(A_BAD); check("unmapped", q, 32'h00);
        bus(1'b1, A_CTL, 32'h3F, 4'hE, r);
        rd(A_CTL); check("sel0 write", q, 32'h40);
        $display("test reset done");
    endtask : t_reset

    task automatic t_events();
        wr(A_CTL, 8'h30);
        wr(A_CNT, 8'h02);
        src.pulse(1); repeat (4) @(posedge clk_i);
        rd(A_CNT); check("cnt 01", q, 32'h01);
        check("irq low", {31'h0, irq}, 32'h0);
        src.pulse(1); repeat (4) @(posedge clk_i);
        check("irq high", {31'h0, irq}, 32'h1);
        rd(A_CNT); check("cnt 00", q, 32'h00);
        rd(A_CTL); check("flag set", q, 32'hB0);
        src.pulse(1); repeat (4) @(posedge clk_i);
        rd(A_CNT); check("wrap", q, 32'hFF);
        wr(A_CTL, 8'h30);
        rd(A_CTL); check("flag clr", q, 32'h30);
        wr(A_CTL, 8'hF0);
        check("inhibit", {31'h0, irq}, 32'h0);
        $display("test events done");
    endtask : t_events

    task automatic t_sources();
        wr(A_CTL, 8'h20);
        wr(A_CNT, 8'h55);
        src.pulse(4); repeat (40) @(posedge clk_i);
        rd(A_CNT); check("stopped", q, 32'h55);
        wr(A_CTL, 8'h10);
        wr(A_CNT, 8'h80);
        repeat (40) @(posedge clk_i);
        rd(A_CNT); check("gate low", q, 32'h80);
        src.hold(1'b1); repeat (40) @(posedge clk_i);
        rd(A_CNT); check("gate high", {31'h0, q < 32'h80}, 32'h1);
        src.hold(1'b0);
        wr(A_CTL, 8'h00);
        rd(A_CNT); r = q;
        repeat (40) @(posedge clk_i);
        rd(A_CNT); check("internal", {31'h0, q != r}, 32'h1);
        $display("test sources done");
    endtask : t_sources

    task automatic t_divider();
        for (int k = 0; k < 8; k++) begin
            wr(A_CTL, 8'h38 | 8'(k));
            rd(A_CTL); check("clear reads 0", q, 32'h30 | k);
            wr(A_CNT, 8'h10);
            src.pulse(3 << k); repeat (4) @(posedge clk_i);
            rd(A_CNT); check("divide", q, 32'h0D);
        end
        $display("test divider done");
    endtask : t_divider

    task automatic t_option();
        prog(8'h65);
        do_reset();
        rd(A_OPT); check("opt kept", q, 32'h65);
        rd(A_CTL); check("fixed ctl", q, 32'h7F);
        wr(A_CTL, 8'h00);
        rd(A_CTL); check("fixed wr", q, 32'h3F);
        wr(A_CNT, 8'h10);
        src.pulse(96); repeat (4) @(posedge clk_i);
        rd(A_CNT); check("fixed count", q, 32'h0D);
        prog(8'h35);
        do_reset();
        rd(A_CTL); check("soft seed", q, 32'h75);
        $display("test option done");
    endtask : t_option

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'h0; dat = 32'h0; opt_prog = 1'b0; opt_data = 8'h00;
        n_fail = 0; cmp_count = 0;
        do_reset();
        t_reset();
        t_events();
        t_sources();
        t_divider();
        t_option();
        complete_run();
    end

    initial begin
        #3000000;
        n_fail++;
        complete_run();
    end
endmodule : testbench
